// ### logic/compare_match_gen.sv
`timescale 1ns/1ns
module compare_match_gen
  import ocu_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // Counter side
  input  wire logic             timer_tick,
  input  wire logic             counter_write,
  input  wire logic [CNT_W-1:0] counter_value,
  input  wire logic [CNT_W-1:0] compare_value,
  // Match outputs
  output logic                  match_raw,
  output logic                  match_event,
  output logic                  compare_match_flag_set
);

  logic block_reg;
  logic flag_pend_reg;

  assign match_raw = counter_value == compare_value;

  // R01 block next cycle
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      block_reg <= BLOCK_RESET;
    else if (counter_write)
      block_reg <= 1'b1;
    else if (timer_tick)
      block_reg <= 1'b0;
  end

  // R02 written-equal match dropped
  assign match_event = timer_tick && match_raw && !block_reg && !counter_write;

  // R18 flag on next tick
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      flag_pend_reg <= 1'b0;
    else if (match_event)
      flag_pend_reg <= 1'b1;
    else if (timer_tick)
      flag_pend_reg <= 1'b0;
  end

  assign compare_match_flag_set = flag_pend_reg && timer_tick;

endmodule : compare_match_gen

// ### logic/ocu_pkg.sv
package ocu_pkg;

  localparam int CNT_W = 16;
  localparam int MODE_W = 2;
  localparam int WGM_W = 4;

  // Compare output mode codes
  localparam logic [1:0] COM_NONE   = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // Values after reset, and counter limits
  localparam logic       WAVE_RESET  = 1'h0;
  localparam logic       BLOCK_RESET = 1'h0;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;

  // Waveform mode codes used by the mode decoder
  localparam logic [3:0] WGM_NORMAL   = 4'h0;
  localparam logic [3:0] WGM_CTC_OCR  = 4'h4;
  localparam logic [3:0] WGM_CTC_ICR  = 4'hc;
  localparam logic [3:0] WGM_RESERVED = 4'hd;

  // Mode summary from the decoder
  typedef struct packed {
    logic pwm;
    logic fast;
  } wave_mode_s;

  // Pin side of one channel
  typedef struct packed {
    logic pin_out;
    logic pin_oe_n;
  } pin_drive_s;

endpackage : ocu_pkg

// ### logic/timer16_compare_output_unit.sv
// Notes on behaviour
// R01: Counter write blocks matches next timer cycle
// R02: Writing counter equal to compare drops match
// R03: Lost TOP match lets counter run to max
// R04: Software avoids writing BOTTOM while counting down
// R05: Software sets output before enabling pin
// R06: Output bit kept across mode changes
// R07: Mode field acts at once on pin
// R08: Reset clears waveform output bit
// R09: Nonzero mode field routes waveform to pin
// R10: Direction bit alone sets pin direction
// R11: Mode zero leaves output bit unchanged
// R12: New mode acts at next match
// R13: Force strobe applies action in non-PWM
// R14: Mode field ignored by input capture
// R15: Mode field does not alter counting
// R16: PWM polarity, else set/clear/toggle
// R17: Force touches output bit only
// R18: Match sets flag next timer cycle
// R19: Decoded PWM indication gates force strobes
`timescale 1ns/1ns
module timer16_compare_output_unit
  import ocu_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // Timer core
  input  wire logic              timer_tick,
  input  wire logic              counter_write,
  input  wire logic [CNT_W-1:0]  counter_value,
  input  wire logic [CNT_W-1:0]  compare_value,
  input  wire logic              at_top,
  input  wire logic              at_bottom,
  input  wire logic              count_down,
  // Control bits
  input  wire logic [WGM_W-1:0]  waveform_mode_select,
  input  wire logic [MODE_W-1:0] compare_output_mode,
  input  wire logic              force_compare_strobe,
  // Port pin
  input  wire logic              port_data_bit,
  input  wire logic              pin_direction_bit,
  output pin_drive_s             pin,
  // Status
  output logic                   waveform_output,
  output logic                   compare_match_flag_set,
  output logic                   match_event
);

  wave_mode_s mode;
  logic       force_ok;
  logic       wave_next;

  wave_mode_decoder u_dec (
    .waveform_mode_select (waveform_mode_select),
    .mode                 (mode)
  );

  // R03 R14 R15 counting and capture stay outside; a lost match is just dropped here
  compare_match_gen u_cmp (
    .sys_clk                (sys_clk),
    .resetn                 (resetn),
    .timer_tick             (timer_tick),
    .counter_write          (counter_write),
    .counter_value          (counter_value),
    .compare_value          (compare_value),
    .match_raw              (),
    .match_event            (match_event),
    .compare_match_flag_set (compare_match_flag_set)
  );

  // R17 force bypasses flag
  // R19 strobe gated
  assign force_ok = force_compare_strobe && !mode.pwm;

  // R16 action select
  always_comb
  begin
    wave_next = waveform_output;
    if (!mode.pwm)
    begin
      // R13 forced action
      if (match_event || force_ok)
      begin
        // R11 R12 mode zero holds, live mode acts
        unique case (compare_output_mode)
          COM_NONE:   wave_next = waveform_output;
          COM_TOGGLE: wave_next = !waveform_output;
          COM_CLEAR:  wave_next = 1'b0;
          COM_SET:    wave_next = 1'b1;
        endcase
      end
    end
    else if (compare_output_mode[1])
    begin
      if (mode.fast)
      begin
        if (match_event)
          wave_next = compare_output_mode[0];
        else if (timer_tick && at_top)
          wave_next = !compare_output_mode[0];
      end
      else if (match_event)
        wave_next = count_down ? !compare_output_mode[0] : compare_output_mode[0];
      else if (timer_tick && at_bottom)
        wave_next = !compare_output_mode[0];
    end
    else if (compare_output_mode == COM_TOGGLE && match_event && mode.fast)
      wave_next = !waveform_output;
  end

  // R08 reset clear, R06 held otherwise
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      waveform_output <= WAVE_RESET;
    else
      waveform_output <= wave_next;
  end

  // R09 output source, R10 direction
  always_comb
  begin
    pin.pin_out  = (compare_output_mode != COM_NONE) ? waveform_output : port_data_bit;
    pin.pin_oe_n = !pin_direction_bit;
  end

endmodule : timer16_compare_output_unit

// ### logic/wave_mode_decoder.sv
`timescale 1ns/1ns
module wave_mode_decoder
  import ocu_pkg::*;
(
  // Mode selection
  input  wire logic [WGM_W-1:0] waveform_mode_select,
  // Decoded mode
  output wave_mode_s            mode
);

  always_comb
  begin
    mode.pwm  = !(waveform_mode_select == WGM_NORMAL || waveform_mode_select == WGM_CTC_OCR ||
                  waveform_mode_select == WGM_CTC_ICR || waveform_mode_select == WGM_RESERVED);
    mode.fast = waveform_mode_select == 4'h5 || waveform_mode_select == 4'h6 ||
                waveform_mode_select == 4'h7 || waveform_mode_select == 4'he ||
                waveform_mode_select == 4'hf;
  end

endmodule : wave_mode_decoder

// ### testbench/ocu_properties.sv
`timescale 1ns/1ns
module ocu_properties
  import ocu_pkg::*;
(
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              resetn,
  // Inputs
  input wire logic              timer_tick,
  input wire logic              counter_write,
  input wire logic [CNT_W-1:0]  counter_value,
  input wire logic [CNT_W-1:0]  compare_value,
  input wire logic [WGM_W-1:0]  waveform_mode_select,
  input wire logic [MODE_W-1:0] compare_output_mode,
  input wire logic              force_compare_strobe,
  input wire logic              port_data_bit,
  input wire logic              pin_direction_bit,
  // Outputs
  input wire pin_drive_s        pin,
  input wire logic              waveform_output,
  input wire logic              match_event
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_PIN_SRC: assert property (pin.pin_out == (|compare_output_mode ? waveform_output : port_data_bit))
    else $error("pin source");
  AST_PIN_DIR: assert property (pin.pin_oe_n == !pin_direction_bit)
    else $error("pin dir");
  AST_WR_NOW: assert property (counter_write |-> !match_event)
    else $error("match in write");
  AST_WR_NEXT: assert property (counter_write ##1 timer_tick |-> !match_event)
    else $error("match after write");
  AST_CAUSE: assert property (match_event |-> timer_tick && counter_value == compare_value)
    else $error("bad match");
  AST_ZERO: assert property (compare_output_mode == COM_NONE |=> $stable(waveform_output))
    else $error("mode 0 moved");
  AST_TGL: assert property (match_event && waveform_mode_select == WGM_NORMAL && compare_output_mode == COM_TOGGLE
    && !force_compare_strobe |=> waveform_output != $past(waveform_output))
    else $error("no toggle");
  AST_FSET: assert property (force_compare_strobe && waveform_mode_select == WGM_NORMAL
    && compare_output_mode == COM_SET |=> waveform_output)
    else $error("force set");
  AST_FCLR: assert property (force_compare_strobe && waveform_mode_select == WGM_NORMAL
    && compare_output_mode == COM_CLEAR |=> !waveform_output)
    else $error("force clear");
  AST_RST: assert property ($rose(resetn) |-> !waveform_output)
    else $error("reset value");
  cover property (match_event);
  cover property (force_compare_strobe && |compare_output_mode);
  cover property (counter_write ##1 timer_tick);
endmodule : ocu_properties
bind timer16_compare_output_unit ocu_properties u_chk (.*);

// ### testbench/port_pin_model.sv
`timescale 1ns/1ns
module port_pin_model
  import ocu_pkg::*;
(
  // Drive from the block
  input  wire pin_drive_s pin,
  // Pad level
  output logic            level
);
  assign level = pin.pin_oe_n ? 1'h1 : pin.pin_out;
endmodule : port_pin_model

// ### testbench/timer16_compare_output_unit_tb.sv
`timescale 1ns/1ns
module timer16_compare_output_unit_tb;
  import ocu_pkg::*;
  localparam logic [1:0] MD [4] = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_NONE};
  localparam logic       EX [4] = '{1'h1, 1'h0, 1'h1, 1'h1};
  logic              sys_clk, resetn, timer_tick, counter_write, force_compare_strobe;
  logic              port_data_bit, pin_direction_bit, at_top, at_bottom, count_down;
  logic [CNT_W-1:0]  counter_value, compare_value;
  logic [WGM_W-1:0]  waveform_mode_select;
  logic [MODE_W-1:0] compare_output_mode;
  pin_drive_s        pin;
  logic              waveform_output, compare_match_flag_set, match_event, pin_level, me;
  int                n_mismatch = 0;
  int                compares = 0;
  int                nflag = 0;
  int                n0;
  timer16_compare_output_unit uut (.*);
  port_pin_model pin_model (.pin(pin), .level(pin_level));
  initial
  begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    compares++;
    if (a !== e)
    begin
      n_mismatch++;
      $display("mismatch %0t %h %h", $time, a, e);
    end
  endtask : chk
  // One cycle of stimulus, sampled mid-cycle
  task automatic stp(input logic t, input logic w, input logic f, input logic [1:0] m);
    @(posedge sys_clk);
    timer_tick <= t;
    counter_write <= w;
    force_compare_strobe <= f;
    compare_output_mode <= m;
    @(negedge sys_clk);
    me = match_event;
    nflag += compare_match_flag_set;
  endtask : stp
  task automatic t_force;
    n0 = nflag;
    for (int i = 0; i < 4; i++)
    begin
      stp(1'h0, 1'h0, 1'h1, MD[i]);
      stp(1'h0, 1'h0, 1'h0, MD[i]);
      chk(waveform_output, EX[i]);
    end
    chk(16'(nflag - n0), 16'h0000);
    @(posedge sys_clk);
    waveform_mode_select <= 4'he;
    stp(1'h0, 1'h0, 1'h1, COM_CLEAR);
    stp(1'h0, 1'h0, 1'h0, COM_CLEAR);
    chk(waveform_output, 1'h1);
    @(posedge sys_clk);
    waveform_mode_select <= WGM_NORMAL;
  endtask : t_force
  task automatic t_pin;
    @(posedge sys_clk);
    pin_direction_bit <= 1'h1;
    stp(1'h0, 1'h0, 1'h0, COM_CLEAR);
    chk(pin_level, 1'h1);
    stp(1'h0, 1'h0, 1'h0, COM_NONE);
    chk(pin_level, 1'h0);
    chk(pin.pin_oe_n, 1'h0);
  endtask : t_pin
  task automatic t_block;
    // counter is never written to BOTTOM while counting down
    stp(1'h0, 1'h1, 1'h0, COM_TOGGLE);
    stp(1'h1, 1'h0, 1'h0, COM_TOGGLE);
    chk(me, 1'h0);
    n0 = nflag;
    stp(1'h1, 1'h0, 1'h0, COM_TOGGLE);
    chk(me, 1'h1);
    stp(1'h0, 1'h0, 1'h0, COM_TOGGLE);
    chk(waveform_output, 1'h0);
    stp(1'h1, 1'h0, 1'h0, COM_NONE);
    stp(1'h0, 1'h0, 1'h0, COM_NONE);
    chk(waveform_output, 1'h0);
    chk(16'(nflag - n0), 16'h0001);
  endtask : t_block
  task automatic t_pwm;
    @(posedge sys_clk);
    waveform_mode_select <= 4'he;
    at_top <= 1'h1;
    counter_value <= 16'h0009;
    stp(1'h1, 1'h0, 1'h0, COM_CLEAR);
    stp(1'h0, 1'h0, 1'h0, COM_CLEAR);
    chk(waveform_output, 1'h1);
    @(posedge sys_clk);
    at_top <= 1'h0;
    counter_value <= 16'h0005;
    stp(1'h1, 1'h0, 1'h0, COM_CLEAR);
    stp(1'h0, 1'h0, 1'h0, COM_CLEAR);
    chk(waveform_output, 1'h0);
    @(posedge sys_clk);
    waveform_mode_select <= 4'h1;
    count_down <= 1'h1;
    stp(1'h1, 1'h0, 1'h0, COM_CLEAR);
    stp(1'h0, 1'h0, 1'h0, COM_CLEAR);
    chk(waveform_output, 1'h1);
    @(posedge sys_clk);
    waveform_mode_select <= WGM_NORMAL;
    count_down <= 1'h0;
    stp(1'h0, 1'h0, 1'h0, COM_NONE);
    chk(waveform_output, 1'h1);
  endtask : t_pwm
  task automatic results;
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  initial
  begin
    {resetn, timer_tick, counter_write, force_compare_strobe, port_data_bit} = '0;
    {pin_direction_bit, at_top, at_bottom, count_down} = '0;
    counter_value = 16'h0005;
    compare_value = 16'h0005;
    waveform_mode_select = WGM_NORMAL;
    compare_output_mode = COM_NONE;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'h1;
    stp(1'h0, 1'h0, 1'h0, COM_NONE);
    chk(waveform_output, 1'h0);
    t_force;
    t_pin;
    t_block;
    t_pwm;
    results;
  end
endmodule : timer16_compare_output_unit_tb
